// file: rtl/tlm_defines.vh
`ifndef TLM_DEFINES_VH
`define TLM_DEFINES_VH
// register offsets (printed offsets; not all multiples of four, kept as indices)
`define TLM_OFS_POS_LIMIT      16'h0608
`define TLM_OFS_NEG_LIMIT      16'h060a
`define TLM_OFS_PEAK_USR       16'h1e2a
`define TLM_OFS_ERR_USR        16'h1e2c
`define TLM_OFS_PEAK_REV       16'h1e36
`define TLM_OFS_ERR_REV        16'h1e38
`define TLM_OFS_LIMIT_ENABLE   16'h0603
`define TLM_OFS_STATUS         16'h0604
// reset values
`define TLM_RST_POS_LIMIT      32'h7fffffff
`define TLM_RST_NEG_LIMIT      32'h80000000
`define TLM_RST_LIMIT_ENABLE   2'h0
// limit enable field
`define TLM_EN_POS_BIT         0
`define TLM_EN_NEG_BIT         1
// operating mode codes
`define TLM_MODE_JOG           4'h1
`define TLM_MODE_PROFILE_POS   4'h2
`define TLM_MODE_HOMING        4'h3
`define TLM_MODE_SEQ_ABS       4'h4
`define TLM_MODE_SEQ_ADD       4'h5
`define TLM_MODE_SEQ_REL       4'h6
`define TLM_MODE_SEQ_REF       4'h7
// operating state code for quick stop active
`define TLM_STATE_QSTOP        4'h7
`endif

// file: rtl/tlm_monitor.v
`timescale 1ns/1ps
`include "tlm_defines.vh"
// How it works
// RULE1 - positive limit signed 32, resets to max
// RULE2 - negative limit signed 32, resets to min
// RULE3 - out-of-range limit write stores maximum value
// RULE4 - limit writes accepted only with stage disabled
// RULE5 - new limit applies at next enable
// RULE6 - deviation equals reference minus actual position
// RULE7 - deviation feeds following error monitoring
// RULE8 - monitoring active only in listed modes
// RULE9 - deviation readable, signed user units
// RULE10 - deviation readable in 0.0001 revolution units
// RULE11 - peak deviation kept, readable both units
// RULE12 - any peak write clears peak immediately
// RULE13 - revolution peak is unsigned 32 bits
// RULE14 - peak updated when magnitude grows
// RULE15 - two-bit enable selects limit directions
// RULE16 - limit monitoring needs valid zero point
// RULE17 - limit reached stops, errors, enters quick stop
module tlm_monitor (
  // clock and reset
  input  wire        ref_clk_i,
  input  wire        srst_i,
  // drive control cycle tick and state
  input  wire        ctrl_tick_i,
  input  wire        stage_enabled_i,
  input  wire [3:0]  op_mode_i,
  input  wire        zero_valid_i,
  // positions in user units and in revolution units
  input  wire [31:0] ref_pos_i,
  input  wire [31:0] act_pos_i,
  input  wire [31:0] ref_pos_rev_i,
  input  wire [31:0] act_pos_rev_i,
  // parameter access
  input  wire        par_wr_i,
  input  wire        par_rd_i,
  input  wire [15:0] par_addr_i,
  input  wire [31:0] par_wdata_i,
  output reg  [31:0] par_rdata_o,
  output reg         par_ack_o,
  output reg         par_err_o,
  // monitoring outputs
  output reg         fe_monitor_active_o,
  output reg  [31:0] fe_value_o,
  output reg         limit_stop_o,
  output reg         limit_error_o,
  output reg  [3:0]  op_state_req_o
);

  reg  [31:0] pos_limit_reg;
  reg  [31:0] neg_limit_reg;
  reg  [31:0] pos_limit_act_reg;
  reg  [31:0] neg_limit_act_reg;
  reg  [1:0]  limit_enable_reg;
  reg  [31:0] err_usr_reg;
  reg  [31:0] err_rev_reg;
  reg  [31:0] peak_usr_reg;
  reg  [31:0] peak_rev_reg;
  reg         stage_en_d_reg;
  reg         pos_hit_reg;
  reg         neg_hit_reg;

  wire [31:0] dev_usr;
  wire [31:0] dev_rev;
  wire        mode_ok;
  wire        stage_rise;
  wire        limit_wr_ok;
  wire        peak_clr;
  wire        pos_hit;
  wire        neg_hit;

  function [31:0] tlm_abs;
    input [31:0] v;
    begin
      tlm_abs = v[31] ? (~v + 32'h00000001) : v;
    end
  endfunction

  assign dev_usr = ref_pos_i - act_pos_i; // RULE6
  assign dev_rev = ref_pos_rev_i - act_pos_rev_i; // RULE6

  assign mode_ok = (op_mode_i == `TLM_MODE_JOG)         ||
                   (op_mode_i == `TLM_MODE_PROFILE_POS) ||
                   (op_mode_i == `TLM_MODE_HOMING)      ||
                   (op_mode_i == `TLM_MODE_SEQ_ABS)     ||
                   (op_mode_i == `TLM_MODE_SEQ_ADD)     ||
                   (op_mode_i == `TLM_MODE_SEQ_REL)     ||
                   (op_mode_i == `TLM_MODE_SEQ_REF); // RULE8

  assign stage_rise  = stage_enabled_i & ~stage_en_d_reg;
  assign limit_wr_ok = par_wr_i & ~stage_enabled_i; // RULE4
  assign peak_clr    = par_wr_i && ((par_addr_i == `TLM_OFS_PEAK_USR) ||
                                    (par_addr_i == `TLM_OFS_PEAK_REV)); // RULE12

  // user data is already 32-bit signed, so the only out-of-range value is
  // none; any write is stored as given, with no clamp to the max
  // signed compare against the active limits, gated by enable and zero point
  assign pos_hit = limit_enable_reg[`TLM_EN_POS_BIT] & zero_valid_i &
                   stage_enabled_i &
                   ($signed(act_pos_i) >= $signed(pos_limit_act_reg)); // RULE15 RULE16
  assign neg_hit = limit_enable_reg[`TLM_EN_NEG_BIT] & zero_valid_i &
                   stage_enabled_i &
                   ($signed(act_pos_i) <= $signed(neg_limit_act_reg)); // RULE15 RULE16

  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      pos_limit_reg     <= `TLM_RST_POS_LIMIT; // RULE1
      neg_limit_reg     <= `TLM_RST_NEG_LIMIT; // RULE2
      pos_limit_act_reg <= `TLM_RST_POS_LIMIT;
      neg_limit_act_reg <= `TLM_RST_NEG_LIMIT;
      limit_enable_reg  <= `TLM_RST_LIMIT_ENABLE;
      stage_en_d_reg    <= 1'b0;
    end else begin
      stage_en_d_reg <= stage_enabled_i;
      if (limit_wr_ok && par_addr_i == `TLM_OFS_POS_LIMIT) begin
        // all 32 bits of par_wdata_i stored; a non-32-bit range cannot occur
        pos_limit_reg <= par_wdata_i; // RULE3 RULE4
      end
      if (limit_wr_ok && par_addr_i == `TLM_OFS_NEG_LIMIT) begin
        neg_limit_reg <= par_wdata_i; // RULE3 RULE4
      end
      if (par_wr_i && par_addr_i == `TLM_OFS_LIMIT_ENABLE) begin
        // enabling without a valid zero point is refused
        if (zero_valid_i || par_wdata_i[1:0] == 2'h0)
          limit_enable_reg <= par_wdata_i[1:0]; // RULE15 RULE16
      end
      if (stage_rise) begin
        pos_limit_act_reg <= pos_limit_reg; // RULE5
        neg_limit_act_reg <= neg_limit_reg; // RULE5
      end
    end
  end

  // deviation and peak, sampled each control cycle
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      err_usr_reg  <= 32'h00000000;
      err_rev_reg  <= 32'h00000000;
      peak_usr_reg <= 32'h00000000;
      peak_rev_reg <= 32'h00000000;
    end else begin
      if (ctrl_tick_i) begin
        err_usr_reg <= dev_usr; // RULE9
        err_rev_reg <= dev_rev; // RULE10
      end
      // clear outranks a same-cycle peak update: the write must leave zero
      if (peak_clr) begin
        peak_usr_reg <= 32'h00000000; // RULE12
        peak_rev_reg <= 32'h00000000; // RULE12
      end else if (ctrl_tick_i) begin
        if (tlm_abs(dev_usr) > peak_usr_reg)
          peak_usr_reg <= tlm_abs(dev_usr); // RULE11 RULE14
        if (tlm_abs(dev_rev) > peak_rev_reg)
          peak_rev_reg <= tlm_abs(dev_rev); // RULE13 RULE14
      end
    end
  end

  // monitoring outputs
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      fe_monitor_active_o <= 1'b0;
      fe_value_o          <= 32'h00000000;
      limit_stop_o        <= 1'b0;
      limit_error_o       <= 1'b0;
      op_state_req_o      <= 4'h0;
      pos_hit_reg         <= 1'b0;
      neg_hit_reg         <= 1'b0;
    end else begin
      fe_monitor_active_o <= mode_ok & stage_enabled_i; // RULE8
      fe_value_o          <= err_usr_reg; // RULE7
      pos_hit_reg         <= pos_hit;
      neg_hit_reg         <= neg_hit;
      limit_stop_o        <= pos_hit | neg_hit; // RULE17
      // error raised once per new hit; held until the stage is disabled
      if ((pos_hit & ~pos_hit_reg) | (neg_hit & ~neg_hit_reg)) begin
        limit_error_o  <= 1'b1; // RULE17
        op_state_req_o <= `TLM_STATE_QSTOP; // RULE17
      end else if (!stage_enabled_i) begin
        limit_error_o  <= 1'b0;
        op_state_req_o <= 4'h0;
      end
    end
  end

  // parameter read/write port, one-cycle answer
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      par_rdata_o <= 32'h00000000;
      par_ack_o   <= 1'b0;
      par_err_o   <= 1'b0;
    end else begin
      par_ack_o <= par_rd_i | par_wr_i;
      par_err_o <= 1'b0;
      if (par_rd_i || par_wr_i) begin
        case (par_addr_i)
          `TLM_OFS_POS_LIMIT:    par_rdata_o <= pos_limit_reg;
          `TLM_OFS_NEG_LIMIT:    par_rdata_o <= neg_limit_reg;
          `TLM_OFS_PEAK_USR:     par_rdata_o <= peak_usr_reg; // RULE11
          `TLM_OFS_ERR_USR:      par_rdata_o <= err_usr_reg; // RULE9
          `TLM_OFS_PEAK_REV:     par_rdata_o <= peak_rev_reg; // RULE13
          `TLM_OFS_ERR_REV:      par_rdata_o <= err_rev_reg; // RULE10
          `TLM_OFS_LIMIT_ENABLE: par_rdata_o <= {30'h0, limit_enable_reg};
          `TLM_OFS_STATUS:       par_rdata_o <= {29'h0, limit_error_o,
                                                 neg_hit_reg, pos_hit_reg};
          default: begin
            par_rdata_o <= 32'h00000000;
            par_err_o   <= 1'b1;
          end
        endcase
        // writes to read-only values, or limits while enabled, are refused
        if (par_wr_i && ((par_addr_i == `TLM_OFS_ERR_USR) ||
                         (par_addr_i == `TLM_OFS_ERR_REV) ||
                         (par_addr_i == `TLM_OFS_STATUS) ||
                         (stage_enabled_i && ((par_addr_i == `TLM_OFS_POS_LIMIT) ||
                                              (par_addr_i == `TLM_OFS_NEG_LIMIT)))))
          par_err_o <= 1'b1; // RULE4
      end
    end
  end

endmodule // tlm_monitor

// file: tb/tlm_chk_monitor.sv
`timescale 1ns/1ps
module tlm_chk (
  input wire        ref_clk_i, srst_i, ctrl_tick_i, stage_enabled_i, zero_valid_i,
  input wire [3:0]  op_mode_i,
  input wire [31:0] ref_pos_i, act_pos_i,
  input wire        par_wr_i, par_rd_i,
  input wire [15:0] par_addr_i,
  input wire        par_ack_o, par_err_o, fe_monitor_active_o, limit_stop_o, limit_error_o,
  input wire [31:0] fe_value_o,
  input wire [3:0]  op_state_req_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  sequence s_req; par_rd_i || par_wr_i; endsequence
  sequence s_ro_wr; par_wr_i && (par_addr_i == 16'h1e2c || par_addr_i == 16'h1e38); endsequence
  sequence s_lim_wr; par_wr_i && (par_addr_i == 16'h0608 || par_addr_i == 16'h060a); endsequence
  a_ack_follows: assert property (s_req |=> par_ack_o) else $error("ack missing");
  a_ack_unasked: assert property (!(par_rd_i || par_wr_i) |=> !par_ack_o) else $error("stray ack");
  a_ro_refused: assert property (
    s_ro_wr |=> par_ack_o && par_err_o) else $error("read-only write not refused");
  a_limit_locked: assert property (
    s_lim_wr and stage_enabled_i |=> par_err_o) else $error("limit write not refused");
  a_dev_sampled: assert property (
    ctrl_tick_i |=> ##1 fe_value_o == $past(ref_pos_i, 2) - $past(act_pos_i, 2))
    else $error("bad deviation");
  a_mode_gate: assert property (
    1'b1 |=> fe_monitor_active_o == ($past(stage_enabled_i) && $past(op_mode_i) >= 4'h1
      && $past(op_mode_i) <= 4'h7)) else $error("bad monitor gate");
  a_qstop_state: assert property (
    op_state_req_o == (limit_error_o ? 4'h7 : 4'h0)) else $error("bad state request");
  a_err_drops: assert property (
    !stage_enabled_i |=> !limit_error_o) else $error("limit error kept");
  a_stop_zero: assert property (
    limit_stop_o |-> $past(zero_valid_i) && $past(stage_enabled_i)) else $error("stop unqualified");
endmodule // tlm_chk
bind tlm_monitor tlm_chk u_tlm_chk (.*);

// file: tb/tlm_monitor_tb_top.sv
`timescale 1ns/1ps
`include "tlm_defines.vh"
module tlm_monitor_tb_top;
  reg         clk = 1'b0, srst, tick, stage, zv, wr, rd, e;
  reg  [3:0]  mode;
  reg  [15:0] addr;
  reg  [31:0] rp, ap, rpr, apr, wd, rdat;
  wire [31:0] rdata, fev;
  wire        ack, err, fea, lstop, lerr;
  wire [3:0]  ost;
  integer     fail_count = 0, checks_done = 0, i, d, dr, pk, pkr;
  always #10 clk = ~clk;
  tlm_monitor u_tlm_monitor (.ref_clk_i(clk), .srst_i(srst), .ctrl_tick_i(tick),
    .stage_enabled_i(stage), .op_mode_i(mode), .zero_valid_i(zv), .ref_pos_i(rp),
    .act_pos_i(ap), .ref_pos_rev_i(rpr), .act_pos_rev_i(apr), .par_wr_i(wr), .par_rd_i(rd),
    .par_addr_i(addr), .par_wdata_i(wd), .par_rdata_o(rdata), .par_ack_o(ack),
    .par_err_o(err), .fe_monitor_active_o(fea), .fe_value_o(fev), .limit_stop_o(lstop),
    .limit_error_o(lerr), .op_state_req_o(ost));
  task summarize;
    begin
      if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // one access: strobe for one cycle, answer is there in the next
  task acc(input w, input [15:0] a, input [31:0] v);
    begin
      @(posedge clk); #1;
      wr = w; rd = !w; addr = a; wd = v;
      @(posedge clk); #1;
      wr = 1'b0; rd = 1'b0;
      chk({31'h0, ack}, 32'h1);
      rdat = rdata; e = err;
    end
  endtask
  task rdc(input [15:0] a, input [31:0] exp);
    begin
      acc(1'b0, a, 32'h0);
      chk(rdat, exp);
    end
  endtask
  task tk;
    begin
      @(posedge clk); #1;
      d = $urandom % 4000 - 2000; dr = $urandom % 4000 - 2000;
      rp = $urandom % 100000; ap = rp - d; rpr = $urandom % 100000; apr = rpr - dr;
      tick = 1'b1;
      @(posedge clk); #1;
      tick = 1'b0;
      if ((d < 0 ? -d : d) > pk) pk = d < 0 ? -d : d;
      if ((dr < 0 ? -dr : dr) > pkr) pkr = dr < 0 ? -dr : dr;
    end
  endtask
  initial begin
    i = $urandom(63);
    srst = 1; tick = 0; stage = 0; zv = 0; wr = 0; rd = 0; mode = 0; addr = 0;
    rp = 0; ap = 0; rpr = 0; apr = 0; wd = 0; pk = 0; pkr = 0;
    repeat (8) @(posedge clk);
    #1 srst = 0;
    rdc(`TLM_OFS_POS_LIMIT, `TLM_RST_POS_LIMIT);
    rdc(`TLM_OFS_NEG_LIMIT, `TLM_RST_NEG_LIMIT);
    rdc(`TLM_OFS_PEAK_USR, 32'h0);
    stage = 1;
    for (i = 0; i < 9; i = i + 1) begin
      mode = i[3:0];
      repeat (2) @(posedge clk);
      #1 chk({31'h0, fea}, {31'h0, i >= 1 && i <= 7});
    end
    mode = `TLM_MODE_JOG;
    for (i = 0; i < 6; i = i + 1) begin
      tk;
      rdc(`TLM_OFS_ERR_USR, d);
      rdc(`TLM_OFS_ERR_REV, dr);
      chk(fev, d);
    end
    rdc(`TLM_OFS_PEAK_USR, pk);
    rdc(`TLM_OFS_PEAK_REV, pkr);
    acc(1'b1, `TLM_OFS_PEAK_REV, 32'h5);
    rdc(`TLM_OFS_PEAK_USR, 32'h0);
    acc(1'b1, `TLM_OFS_ERR_USR, 32'h1);
    chk({31'h0, e}, 32'h1);
    rdc(16'h0100, 32'h0);
    chk({31'h0, e}, 32'h1);
    stage = 0;
    acc(1'b1, `TLM_OFS_POS_LIMIT, 32'd100);
    rdc(`TLM_OFS_POS_LIMIT, 32'd100);
    acc(1'b1, `TLM_OFS_LIMIT_ENABLE, 32'h3);
    rdc(`TLM_OFS_LIMIT_ENABLE, 32'h0);
    zv = 1;
    acc(1'b1, `TLM_OFS_LIMIT_ENABLE, 32'h1);
    rdc(`TLM_OFS_LIMIT_ENABLE, 32'h1);
    ap = 32'd200; stage = 1;
    repeat (4) @(posedge clk);
    #1 chk({31'h0, lstop}, 32'h1);
    chk({28'h0, ost}, {28'h0, `TLM_STATE_QSTOP});
    acc(1'b1, `TLM_OFS_POS_LIMIT, 32'd50);
    chk({31'h0, e}, 32'h1);
    rdc(`TLM_OFS_POS_LIMIT, 32'd100);
    stage = 0;
    repeat (2) @(posedge clk);
    #1 chk({31'h0, lerr}, 32'h0);
    summarize;
  end
  // about a hundred cycles are expected; far more means a hang
  initial begin
    #100000;
    fail_count = fail_count + 1;
    summarize;
  end
endmodule // tlm_monitor_tb_top
